// ==== hw/cfpm_ctrl.sv ====
`timescale 1ns/1ps

// Operation
// - Standby key while operating enters standby and lights standby indicator.
// - Standby key in standby runs self-test: 10 MHz, address, then measuring.
// - Battery variant: standby key toggles power; each power-up runs self-test.
// - Restart key in local restarts and starts a measurement, settings kept.
// - Restart key in remote returns to local and starts a measurement.
// - Restart key is ignored while local lockout is asserted.
// - Every restart reloads bus address from rear switches.
// - Bus address is a five-bit switch bank value.
// - Hold-interval key advances to the next measurement hold time.
// - Two hold indicators: one lit per interval, none zero, both infinite.
// - Delta key toggles delta mode; display is frequency minus first reading.
// - Remote controller may write the delta reference directly.
// - Enabling delta at 0.01 Hz low-band resolution forces 1 Hz.
// - Failed reference retried five times, then delta turns off.
// - Resolution-up refines one step, saturating 0.01 Hz low (0.1 Hz while delta is on), 1 Hz high.
// - Resolution-down coarsens one step, saturating 100 Hz low, 1 MHz high.
// - Band key cycles low high-impedance, low fifty ohm, high band.
// - Power meter state is remembered across band changes.
// - Band indicators show the active selection.
// - Power-meter key toggles power measurement, only in high band.
module cfpm_ctrl #(
  parameter int TEST_CYC = cfpm_pkg::TEST_PHASE_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                srst,
  input  wire logic [4:0]          addr_sw,
  input  wire logic                battery_variant,
  input  wire logic [31:0]         meas_freq,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output cfpm_pkg::cfpm_panel_t    panel,
  output logic [4:0]               bus_addr,
  output logic                     remote_led,
  output logic [31:0]              display_freq
);

  // ==========================================================================
  // Switch synchronisers
  logic [4:0] sw_m_r, sw_s_r;
  logic       bv_m_r, bv_s_r;
  always_ff @(posedge sys_clk) begin
    sw_m_r <= addr_sw;
    sw_s_r <= sw_m_r;
    bv_m_r <= battery_variant;
    bv_s_r <= bv_m_r;
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_go;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [31:0] status_word;
  logic        awready_r, awready_nxt, wready_r, wready_nxt, arready_r, arready_nxt;
  logic        remote_r, remote_nxt, llo_r, llo_nxt;
  logic [31:0] dref_r, dref_nxt;

  function automatic logic known_addr(input logic [7:0] a);
    return a == cfpm_pkg::ADDR_KEYS || a == cfpm_pkg::ADDR_STATUS ||
           a == cfpm_pkg::ADDR_DREF || a == cfpm_pkg::ADDR_REMOTE ||
           a == cfpm_pkg::ADDR_MEAS;
  endfunction

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awa_nxt     = awa_r;
    wd_nxt      = wd_r;
    bvalid_nxt  = bvalid_r && !s_axi_bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_awvalid && !aw_hold_r && !bvalid_r) begin
      aw_hold_nxt = 1'b1;
      awa_nxt     = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_hold_r && !bvalid_r) begin
      w_hold_nxt = 1'b1;
      wd_nxt     = s_axi_wdata;
    end
    wr_go   = aw_hold_r && w_hold_r;
    wr_addr = awa_r;
    wr_data = wd_r;
    if (wr_go) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = known_addr(awa_r) ? cfpm_pkg::AXI_OKAY : cfpm_pkg::AXI_SLVERR;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = known_addr(s_axi_araddr) ? cfpm_pkg::AXI_OKAY : cfpm_pkg::AXI_SLVERR;
      unique case (s_axi_araddr)
        cfpm_pkg::ADDR_STATUS: rdata_nxt = status_word;
        cfpm_pkg::ADDR_DREF:   rdata_nxt = dref_r;
        cfpm_pkg::ADDR_REMOTE: rdata_nxt = {30'h0, llo_r, remote_r};
        default:               rdata_nxt = 32'h0;
      endcase
    end
    // Ready flags registered from the next holding state
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt  = !w_hold_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awa_r     <= 8'h00;
      wd_r      <= 32'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      arready_r <= 1'b1;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r  <= w_hold_nxt;
      awa_r     <= awa_nxt;
      wd_r      <= wd_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      arready_r <= arready_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  // ==========================================================================
  // Write decodes
  logic        wr_keys, wr_dref, wr_rem, wr_meas;
  logic [31:0] keys;
  assign wr_keys = wr_go && wr_addr == cfpm_pkg::ADDR_KEYS;
  assign wr_dref = wr_go && wr_addr == cfpm_pkg::ADDR_DREF;
  assign wr_rem  = wr_go && wr_addr == cfpm_pkg::ADDR_REMOTE;
  assign wr_meas = wr_go && wr_addr == cfpm_pkg::ADDR_MEAS;
  assign keys    = wr_keys ? wr_data : 32'h0;

  logic k_stby, k_rst, k_hold, k_delta, k_rup, k_rdn, k_band, k_pwr;
  logic m_done, m_fail, running;
  assign k_stby  = keys[cfpm_pkg::KEY_STBY];
  assign k_rst   = keys[cfpm_pkg::KEY_RST] && running;
  assign k_hold  = keys[cfpm_pkg::KEY_HOLD] && running;
  assign k_delta = keys[cfpm_pkg::KEY_DELTA] && running;
  assign k_rup   = keys[cfpm_pkg::KEY_RUP] && running;
  assign k_rdn   = keys[cfpm_pkg::KEY_RDN] && running;
  assign k_band  = keys[cfpm_pkg::KEY_BAND] && running;
  assign k_pwr   = keys[cfpm_pkg::KEY_PWR] && running;
  assign m_done  = wr_meas && wr_data[cfpm_pkg::MEAS_DONE];
  assign m_fail  = wr_meas && wr_data[cfpm_pkg::MEAS_FAIL];

  // ==========================================================================
  // Mode state: standby, self-test, power
  cfpm_pkg::cfpm_state_t st_r, st_nxt;
  logic [31:0] tcnt_r, tcnt_nxt;
  logic [4:0]  addr_r, addr_nxt;
  logic        restart;
  logic        start_r, start_nxt;

  assign running = st_r == cfpm_pkg::ST_RUN;
  assign restart = k_rst && !llo_r;

  always_comb begin
    st_nxt     = st_r;
    tcnt_nxt   = tcnt_r;
    remote_nxt = remote_r;
    llo_nxt    = llo_r;
    addr_nxt   = addr_r;
    start_nxt  = 1'b0;
    if (wr_rem) begin
      remote_nxt = wr_data[cfpm_pkg::REM_REMOTE];
      llo_nxt    = wr_data[cfpm_pkg::REM_LLO];
    end
    if (restart) begin
      remote_nxt = 1'b0;
      addr_nxt   = sw_s_r;
      start_nxt  = 1'b1;
    end
    unique case (st_r)
      cfpm_pkg::ST_RUN:
        if (k_stby)
          st_nxt = bv_s_r ? cfpm_pkg::ST_OFF : cfpm_pkg::ST_STBY;
      cfpm_pkg::ST_STBY, cfpm_pkg::ST_OFF:
        if (k_stby) begin
          st_nxt   = cfpm_pkg::ST_T10M;
          tcnt_nxt = 32'h0;
        end
      cfpm_pkg::ST_T10M:
        if (tcnt_r == 32'(TEST_CYC - 1)) begin
          st_nxt   = cfpm_pkg::ST_TADDR;
          tcnt_nxt = 32'h0;
          addr_nxt = sw_s_r;
        end else begin
          tcnt_nxt = tcnt_r + 32'h1;
        end
      cfpm_pkg::ST_TADDR:
        if (tcnt_r == 32'(TEST_CYC - 1)) begin
          st_nxt    = cfpm_pkg::ST_RUN;
          start_nxt = 1'b1;
        end else begin
          tcnt_nxt = tcnt_r + 32'h1;
        end
      default: st_nxt = cfpm_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r     <= cfpm_pkg::ST_T10M;
      tcnt_r   <= 32'h0;
      remote_r <= 1'b0;
      llo_r    <= 1'b0;
      addr_r   <= 5'h00;
      start_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      tcnt_r   <= tcnt_nxt;
      remote_r <= remote_nxt;
      llo_r    <= llo_nxt;
      addr_r   <= addr_nxt;
      start_r  <= start_nxt;
    end
  end

  // ==========================================================================
  // User settings: hold, band, resolution, power meter, delta
  cfpm_pkg::cfpm_hold_t hold_r, hold_nxt;
  cfpm_pkg::cfpm_band_t band_r, band_nxt;
  cfpm_pkg::cfpm_df_t   df_r, df_nxt;
  logic [3:0]  res_lo_r, res_lo_nxt, res_hi_r, res_hi_nxt;
  logic        pm_r, pm_nxt;
  logic [2:0]  tries_r, tries_nxt;
  logic        hi_band;
  assign hi_band = band_r == cfpm_pkg::BAND_HI;

  always_comb begin
    hold_nxt   = hold_r;
    band_nxt   = band_r;
    df_nxt     = df_r;
    res_lo_nxt = res_lo_r;
    res_hi_nxt = res_hi_r;
    pm_nxt     = pm_r;
    tries_nxt  = tries_r;
    dref_nxt   = dref_r;
    if (k_hold)
      hold_nxt = cfpm_pkg::cfpm_hold_t'(hold_r + 2'h1);
    unique case (band_r)
      cfpm_pkg::BAND_LO_HIZ: if (k_band) band_nxt = cfpm_pkg::BAND_LO_50;
      cfpm_pkg::BAND_LO_50:  if (k_band) band_nxt = cfpm_pkg::BAND_HI;
      cfpm_pkg::BAND_HI:     if (k_band) band_nxt = cfpm_pkg::BAND_LO_HIZ;
      default:               band_nxt = cfpm_pkg::BAND_LO_HIZ;
    endcase
    if (k_pwr && hi_band)
      pm_nxt = !pm_r;
    if (k_rup) begin
      if (hi_band && res_hi_r < cfpm_pkg::RES_1HZ)
        res_hi_nxt = res_hi_r + 4'h1;
      if (!hi_band && res_lo_r < cfpm_pkg::RES_10MHZ_ &&
          !(df_r != cfpm_pkg::DF_OFF && res_lo_r + 4'h1 == cfpm_pkg::RES_10MHZ_))
        res_lo_nxt = res_lo_r + 4'h1;
    end
    if (k_rdn) begin
      if (hi_band && res_hi_r > cfpm_pkg::RES_1MHZ)
        res_hi_nxt = res_hi_r - 4'h1;
      if (!hi_band && res_lo_r > cfpm_pkg::RES_100HZ)
        res_lo_nxt = res_lo_r - 4'h1;
    end
    unique case (df_r)
      cfpm_pkg::DF_OFF:
        if (k_delta) begin
          df_nxt    = cfpm_pkg::DF_WAIT;
          tries_nxt = 3'h0;
          if (res_lo_nxt == cfpm_pkg::RES_10MHZ_)
            res_lo_nxt = cfpm_pkg::RES_1HZ;
        end
      cfpm_pkg::DF_WAIT:
        if (k_delta) begin
          df_nxt = cfpm_pkg::DF_OFF;
        end else if (m_done) begin
          df_nxt   = cfpm_pkg::DF_ON;
          dref_nxt = meas_freq;
        end else if (m_fail) begin
          tries_nxt = tries_r + 3'h1;
          if (tries_r == cfpm_pkg::DELTA_TRIES - 3'h1)
            df_nxt = cfpm_pkg::DF_OFF;
        end
      cfpm_pkg::DF_ON:
        if (k_delta) df_nxt = cfpm_pkg::DF_OFF;
      default: df_nxt = cfpm_pkg::DF_OFF;
    endcase
    if (wr_dref) begin
      dref_nxt = wr_data;
      if (df_r == cfpm_pkg::DF_WAIT) df_nxt = cfpm_pkg::DF_ON;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hold_r   <= cfpm_pkg::HOLD_0P3;
      band_r   <= cfpm_pkg::BAND_LO_HIZ;
      df_r     <= cfpm_pkg::DF_OFF;
      res_lo_r <= cfpm_pkg::RES_LO_RST;
      res_hi_r <= cfpm_pkg::RES_HI_RST;
      pm_r     <= 1'b0;
      tries_r  <= 3'h0;
      dref_r   <= 32'h0;
    end else begin
      hold_r   <= hold_nxt;
      band_r   <= band_nxt;
      df_r     <= df_nxt;
      res_lo_r <= res_lo_nxt;
      res_hi_r <= res_hi_nxt;
      pm_r     <= pm_nxt;
      tries_r  <= tries_nxt;
      dref_r   <= dref_nxt;
    end
  end

  assign status_word = {5'h0, addr_r, tries_r, res_hi_r, res_lo_r,
                        pm_r, df_r, band_r, hold_r, remote_r, st_r};

  // ==========================================================================
  // Registered panel outputs
  cfpm_pkg::cfpm_panel_t panel_r, panel_nxt;
  logic [31:0] disp_r, disp_nxt;

  always_comb begin
    panel_nxt                 = '0;
    panel_nxt.standby_led     = st_r == cfpm_pkg::ST_STBY;
    panel_nxt.power_led       = st_r != cfpm_pkg::ST_OFF;
    panel_nxt.test_10m        = st_r == cfpm_pkg::ST_T10M;
    panel_nxt.test_addr       = st_r == cfpm_pkg::ST_TADDR;
    panel_nxt.meas_start      = start_r;
    panel_nxt.hold_leds       = hold_r;
    panel_nxt.delta_led       = df_r != cfpm_pkg::DF_OFF;
    panel_nxt.res_step        = hi_band ? res_hi_r : res_lo_r;
    panel_nxt.band_leds       = {hi_band, band_r == cfpm_pkg::BAND_LO_50,
                                 band_r == cfpm_pkg::BAND_LO_HIZ};
    panel_nxt.power_meter_led = pm_r && hi_band;
    disp_nxt = (df_r == cfpm_pkg::DF_ON) ? meas_freq - dref_r : meas_freq;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      panel_r <= '0;
      disp_r  <= 32'h0;
    end else begin
      panel_r <= panel_nxt;
      disp_r  <= disp_nxt;
    end
  end

  assign panel        = panel_r;
  assign bus_addr     = addr_r;
  assign remote_led   = remote_r;
  assign display_freq = disp_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  lockout_blocks_a: assert property (k_rst && llo_r |=> !start_r)
    else $error("restart taken under lockout");
  restart_addr_a: assert property (restart |=> addr_r == $past(sw_s_r))
    else $error("address not reloaded");
  restart_local_a: assert property (restart |=> !remote_r && start_r)
    else $error("restart did not return to local");
  hold_wrap_a: assert property (k_hold && hold_r == cfpm_pkg::HOLD_INF
                                |=> hold_r == cfpm_pkg::HOLD_ZERO)
    else $error("hold did not wrap");
  delta_res_a: assert property (df_r != cfpm_pkg::DF_OFF
                                |-> res_lo_r != cfpm_pkg::RES_10MHZ_)
    else $error("delta with finest resolution");
  delta_retry_a: assert property (df_r == cfpm_pkg::DF_WAIT && m_fail && !k_delta
                                  && !wr_dref && tries_r == 3'h4
                                  |=> df_r == cfpm_pkg::DF_OFF)
    else $error("delta not dropped after five failures");
  pm_lowband_a: assert property (k_pwr && !hi_band |=> $stable(pm_r))
    else $error("power meter changed in low band");
  res_hi_sat_a: assert property (res_hi_r <= cfpm_pkg::RES_1HZ)
    else $error("high band resolution too fine");
  stby_enter_a: assert property (running && k_stby && !bv_s_r
                                 |=> ##1 panel.standby_led)
    else $error("standby indicator not lit");

endmodule // cfpm_ctrl

// ==== hw/cfpm_pkg.sv ====
package cfpm_pkg;

  // ==========================================================================
  // Register map (AXI4-Lite byte addresses)
  localparam logic [7:0] ADDR_KEYS   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DREF   = 8'h08;
  localparam logic [7:0] ADDR_REMOTE = 8'h0c;
  localparam logic [7:0] ADDR_MEAS   = 8'h10;

  // ==========================================================================
  // Key strobe bit positions in the key register
  localparam int KEY_STBY   = 0;
  localparam int KEY_RST    = 1;
  localparam int KEY_HOLD   = 2;
  localparam int KEY_DELTA  = 3;
  localparam int KEY_RUP    = 4;
  localparam int KEY_RDN    = 5;
  localparam int KEY_BAND   = 6;
  localparam int KEY_PWR    = 7;
  localparam int KEY_BATT   = 8;

  // Remote register bits
  localparam int REM_REMOTE = 0;
  localparam int REM_LLO    = 1;

  // Measurement event bits
  localparam int MEAS_DONE  = 0;
  localparam int MEAS_FAIL  = 1;

  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  localparam int ADDR_W = 5;

  // ==========================================================================
  // Resolution steps, coarse to fine
  // 0: 1 MHz, 1: 100 kHz, 2: 10 kHz, 3: 1 kHz, 4: 100 Hz,
  // 5: 10 Hz, 6: 1 Hz, 7: 0.1 Hz, 8: 0.01 Hz
  localparam logic [3:0] RES_1MHZ   = 4'h0;
  localparam logic [3:0] RES_100HZ  = 4'h4;
  localparam logic [3:0] RES_1HZ    = 4'h6;
  localparam logic [3:0] RES_10MHZ_ = 4'h8;
  localparam logic [3:0] RES_LO_RST = 4'h6;
  localparam logic [3:0] RES_HI_RST = 4'h3;

  localparam logic [2:0] DELTA_TRIES = 3'h5;

  // Self-test display phase lengths, ms
  localparam int TEST_PHASE_MS = 1000;
  localparam int CLK_KHZ       = 50000;
  localparam int TEST_PHASE_CYC = TEST_PHASE_MS * CLK_KHZ;

  typedef enum logic [1:0] {
    HOLD_ZERO = 2'b00,
    HOLD_0P3  = 2'b01,
    HOLD_3P0  = 2'b10,
    HOLD_INF  = 2'b11
  } cfpm_hold_t;

  typedef enum logic [1:0] {
    BAND_LO_HIZ = 2'b00,
    BAND_LO_50  = 2'b01,
    BAND_HI     = 2'b11
  } cfpm_band_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_STBY  = 3'b001,
    ST_T10M  = 3'b011,
    ST_TADDR = 3'b010,
    ST_OFF   = 3'b110
  } cfpm_state_t;

  typedef enum logic [1:0] {
    DF_OFF  = 2'b00,
    DF_WAIT = 2'b01,
    DF_ON   = 2'b11
  } cfpm_df_t;

  typedef struct packed {
    logic       standby_led;
    logic       power_led;
    logic       test_10m;
    logic       test_addr;
    logic       meas_start;
    logic [1:0] hold_leds;
    logic       delta_led;
    logic [3:0] res_step;
    logic [2:0] band_leds;
    logic       power_meter_led;
  } cfpm_panel_t;

endpackage

// ==== dv/cfpm_axi_master.sv ====
`timescale 1ns/1ps
// ============================================================
// Keys and remote controller, as a register bus master
module cfpm_axi_master (
  input  wire logic        sys_clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;

  // Keys, lockout and reference loads all go through here
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (!aw && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge sys_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // cfpm_axi_master

// ==== dv/cfpm_ctrl_tb.sv ====
`timescale 1ns/1ps
module cfpm_ctrl_tb;
  logic                  sys_clk = 1'b0;
  logic                  srst = 1'b1;
  logic [4:0]            addr_sw = 5'h0a;
  logic                  battery_variant = 1'b0;
  logic [31:0]           meas_freq = 32'h0;
  logic [7:0]            awaddr, araddr;
  logic [31:0]           wdata, rdata;
  logic [1:0]            bresp, rresp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  cfpm_pkg::cfpm_panel_t panel;
  logic [4:0]            bus_addr;
  logic                  remote_led;
  logic [31:0]           display_freq;
  int                    err_count = 0;
  int                    samples_checked = 0;
  int                    starts = 0;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (panel.meas_start === 1'b1) starts++;

  cfpm_ctrl #(.TEST_CYC(8)) cfpm_ctrl_inst (.sys_clk(sys_clk), .srst(srst),
    .addr_sw(addr_sw), .battery_variant(battery_variant), .meas_freq(meas_freq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .panel(panel), .bus_addr(bus_addr), .remote_led(remote_led), .display_freq(display_freq));

  cfpm_axi_master cfpm_axi_master_inst (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ============================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    cfpm_axi_master_inst.wr(a, d, r);
    chk(32'(r), 32'(cfpm_pkg::AXI_OKAY));
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic key(input int k);
    wreg(cfpm_pkg::ADDR_KEYS, 32'h1 << k);
  endtask

  task automatic wait_run;
    for (int i = 0; i < 100 && panel.test_10m === 1'b1; i++) @(posedge sys_clk);
    chk(panel.test_addr, 32'h1);
    for (int i = 0; i < 100 && panel.test_addr === 1'b1; i++) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    results();
  end

  // ============================================================
  // Tests
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(panel.test_10m, 32'h1);
    wait_run();
    chk(bus_addr, 32'h0a);
    for (int i = 0; i < 4; i++) begin
      key(cfpm_pkg::KEY_HOLD);
      chk(panel.hold_leds, 32'((i + 2) % 4));
    end
    $display("test hold done");
    repeat (3) key(cfpm_pkg::KEY_RUP);
    chk(panel.res_step, 32'h8);
    key(cfpm_pkg::KEY_DELTA);
    chk(panel.res_step, 32'h6);
    meas_freq <= 32'h3e8;
    wreg(cfpm_pkg::ADDR_MEAS, 32'h1);
    meas_freq <= 32'h5dc;
    repeat (3) @(posedge sys_clk);
    chk(display_freq, 32'h1f4);
    wreg(cfpm_pkg::ADDR_DREF, 32'hc8);
    chk(display_freq, 32'h514);
    cfpm_axi_master_inst.rd(cfpm_pkg::ADDR_DREF, d, r);
    chk(d, 32'hc8);
    key(cfpm_pkg::KEY_DELTA);
    chk(panel.delta_led, 32'h0);
    repeat (3) key(cfpm_pkg::KEY_RDN);
    chk(panel.res_step, 32'h4);
    key(cfpm_pkg::KEY_DELTA);
    repeat (4) wreg(cfpm_pkg::ADDR_MEAS, 32'h2);
    chk(panel.delta_led, 32'h1);
    wreg(cfpm_pkg::ADDR_MEAS, 32'h2);
    chk(panel.delta_led, 32'h0);
    $display("test delta done");
    key(cfpm_pkg::KEY_PWR);
    chk(panel.power_meter_led, 32'h0);
    key(cfpm_pkg::KEY_BAND);
    chk(panel.band_leds, 32'h2);
    key(cfpm_pkg::KEY_BAND);
    chk(panel.band_leds, 32'h4);
    repeat (4) key(cfpm_pkg::KEY_RDN);
    chk(panel.res_step, 32'h0);
    repeat (7) key(cfpm_pkg::KEY_RUP);
    chk(panel.res_step, 32'h6);
    key(cfpm_pkg::KEY_PWR);
    chk(panel.power_meter_led, 32'h1);
    key(cfpm_pkg::KEY_BAND);
    chk(panel.band_leds, 32'h1);
    repeat (2) key(cfpm_pkg::KEY_BAND);
    chk(panel.power_meter_led, 32'h1);
    $display("test band done");
    wreg(cfpm_pkg::ADDR_REMOTE, 32'h1);
    chk(remote_led, 32'h1);
    addr_sw <= 5'h15;
    n = starts;
    key(cfpm_pkg::KEY_RST);
    chk(remote_led, 32'h0);
    chk(bus_addr, 32'h15);
    chk(32'(starts > n), 32'h1);
    chk(panel.hold_leds, 32'h1);
    wreg(cfpm_pkg::ADDR_REMOTE, 32'h3);
    addr_sw <= 5'h03;
    key(cfpm_pkg::KEY_RST);
    chk(bus_addr, 32'h15);
    chk(remote_led, 32'h1);
    cfpm_axi_master_inst.rd(8'h20, d, r);
    chk(32'(r), 32'(cfpm_pkg::AXI_SLVERR));
    chk(d, 32'h0);
    cfpm_axi_master_inst.wr(8'h20, 32'h0, r);
    chk(32'(r), 32'(cfpm_pkg::AXI_SLVERR));
    $display("test restart done");
    key(cfpm_pkg::KEY_STBY);
    chk(panel.standby_led, 32'h1);
    key(cfpm_pkg::KEY_STBY);
    chk(panel.test_10m, 32'h1);
    wait_run();
    chk(panel.standby_led, 32'h0);
    $display("test standby done");
    battery_variant <= 1'b1;
    repeat (3) @(posedge sys_clk);
    key(cfpm_pkg::KEY_STBY);
    chk(panel.power_led, 32'h0);
    chk(panel.standby_led, 32'h0);
    key(cfpm_pkg::KEY_STBY);
    chk(panel.test_10m, 32'h1);
    wait_run();
    chk(panel.power_led, 32'h1);
    $display("test battery done");
    results();
  end
endmodule // cfpm_ctrl_tb
